// ===== hdl/sct_pkg.sv
// Constants shared by the serial channel transport block.
// Assumes a 250 MHz system clock and a parallel frame port to the serdes.
package sct_pkg;

  localparam int CLK_HZ = 250_000_000;
  localparam int SAMPLE_HZ = 16_500_000;
  localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
  localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_DIV - 1);
  localparam int ACT_HOLD_MS = 20;
  localparam int ACT_HOLD_CYC = (CLK_HZ / 1000) * ACT_HOLD_MS;
  localparam int CHAR_BITS = 10;

  localparam int BAUD_9K6 = 9600;
  localparam int BAUD_19K2 = 19200;
  localparam int BAUD_38K4 = 38400;
  localparam int BAUD_57K6 = 57600;
  localparam int BAUD_115K2 = 115200;
  localparam int BAUD_230K4 = 230400;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_BIT_TIME = 8'h10;

  localparam int CTRL_SEL_A = 0;
  localparam int CTRL_SEL_B = 1;
  localparam int CTRL_RATE_LSB = 2;
  localparam int CTRL_AUTOBAUD = 5;
  localparam int CTRL_TERM = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_006C;

  localparam int IRQ_W = 4;
  localparam int IRQ_LOCAL_LOST = 0;
  localparam int IRQ_REMOTE_LOST = 1;
  localparam int IRQ_OPTICAL_LOST = 2;
  localparam int IRQ_FRAME_ERR = 3;

  localparam int FRAME_W = 5;
  localparam int FR_CH1 = 0;
  localparam int FR_CH2 = 1;
  localparam int FR_CH3 = 2;
  localparam int FR_DDATA = 3;
  localparam int FR_DCLK = 4;
  localparam int ACT_N = 6;

  typedef enum logic [1:0] {
    TA_LISTEN = 2'b01,
    TA_DRIVE = 2'b10
  } sct_ta_e;

endpackage

// ===== hdl/sct_ch_if.sv
// Signals between the transport top and its activity and turnaround units.
// Assumes all parties run on the system clock.
`timescale 1ns/10ps
`default_nettype none
interface sct_ch_if;
  logic [5:0] act_edge;
  logic [5:0] act_lamp;
  logic link_ch3;
  logic mode_422;
  logic autobaud;
  logic [15:0] sel_bit;
  logic drive_en;
  logic [15:0] eff_bit;
  modport act_mp (input act_edge, output act_lamp);
  modport ta_mp (input link_ch3, mode_422, autobaud, sel_bit,
                 output drive_en, eff_bit);
endinterface
`default_nettype wire

// ===== hdl/sct_activity.sv
// Pulse stretchers turning data edges into visible activity lamps.
// Assumes edge pulses on the system clock, one per data transition.
`timescale 1ns/10ps
`default_nettype none
module sct_activity #(
  parameter int HOLD_CYC = sct_pkg::ACT_HOLD_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  sct_ch_if.act_mp ch
);
  genvar g;
  generate
    for (g = 0; g < sct_pkg::ACT_N; g++) begin : g_lamp
      logic [22:0] cnt_reg;
      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          cnt_reg <= 23'h00_0000;
        end else if (ch.act_edge[g]) begin
          cnt_reg <= 23'(HOLD_CYC);
        end else if (cnt_reg != 23'h00_0000) begin
          cnt_reg <= cnt_reg - 23'h00_0001;
        end
      end
      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          ch.act_lamp[g] <= 1'b0;
        end else begin
          ch.act_lamp[g] <= ch.act_edge[g] || (cnt_reg > 23'h00_0001);
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== hdl/sct_turnaround.sv
// Half-duplex driver control and autobaud bit time for the third channel.
// Assumes link data idles high (mark) between characters.
`timescale 1ns/10ps
`default_nettype none
module sct_turnaround (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  sct_ch_if.ta_mp ch
);
  sct_pkg::sct_ta_e state_reg;
  logic prev_reg;
  logic [19:0] run_reg;
  logic [15:0] min_reg;
  logic [15:0] slow_bit;
  logic [19:0] hold;
  logic edge_seen;

  assign slow_bit = 16'(sct_pkg::CLK_HZ / sct_pkg::BAUD_9K6);
  assign edge_seen = ch.link_ch3 ^ prev_reg;
  assign hold = 20'(ch.eff_bit) * 20'(sct_pkg::CHAR_BITS);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      prev_reg <= 1'b1;
      run_reg <= 20'h0_0000;
    end else begin
      prev_reg <= ch.link_ch3;
      if (edge_seen) begin
        run_reg <= 20'h0_0001;
      end else if (run_reg != 20'hF_FFFF) begin
        run_reg <= run_reg + 20'h0_0001;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      min_reg <= 16'h0000;
    end else if (state_reg == sct_pkg::TA_LISTEN && !edge_seen) begin
      min_reg <= slow_bit;
    end else if (edge_seen && run_reg < 20'(min_reg)) begin
      min_reg <= run_reg[15:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ch.eff_bit <= slow_bit;
    end else if (ch.autobaud && min_reg > ch.sel_bit) begin
      ch.eff_bit <= min_reg;
    end else begin
      ch.eff_bit <= ch.sel_bit;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= sct_pkg::TA_LISTEN;
    end else begin
      unique case (state_reg)
        sct_pkg::TA_LISTEN: begin
          if (!ch.link_ch3) begin
            state_reg <= sct_pkg::TA_DRIVE;
          end
        end
        sct_pkg::TA_DRIVE: begin
          if (ch.link_ch3 && run_reg >= hold) begin
            state_reg <= sct_pkg::TA_LISTEN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ch.drive_en <= 1'b0;
    end else begin
      ch.drive_en <= ch.mode_422 || (state_reg == sct_pkg::TA_DRIVE)
                     || !ch.link_ch3;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/sct_top.sv
// Serial channel transport: two RS-232 and one RS-485/RS-422 channel
// sampled into a frame for the optical serdes, plus link status lamps.
// Assumes a serdes frame port and register bus on sys_clk; the other pins are asynchronous.
//
// Contract
// - Two RS-232 channels and one channel set statically to RS-485 or RS-422.
// - Every channel passes at least 115.2 Kbaud, the RS-422 one 2.5 Mbps.
// - RS-232 lines are time sampled at 16.5 Msps with no rate or framing; the code samples every 15 clocks, about 16.67 Msps.
// - RS-485 mode accepts one of six fixed rates from 9.6K to 230.4K baud.
// - With autobaud on, the RS-485 rate is detected up to the selected maximum.
// - With autobaud off, the RS-485 channel runs at the selected rate only.
// - RS-422 ignores rate and autobaud and passes any rate, 2.5 Mbaud and up.
// - Reset default is RS-485, autobaud, 57.6K maximum, termination on.
// - Local link good lights only while the deserializer gets clean data.
// - Remote link lights only while the link is up and the stream in sync.
// - Each channel has a transmit lamp lit while it sends data out.
// - Each channel has a receive lamp lit while data arrives on it.
// - Optical present follows the transceiver signal-detect report.
// - Channels and daughter clock and data share one frame, unpacked at the far end.
`timescale 1ns/10ps
`default_nettype none
module sct_top #(
  parameter int ACT_HOLD_CYC = sct_pkg::ACT_HOLD_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o,
  input wire logic rs232_rx1_i,
  input wire logic rs232_rx2_i,
  input wire logic rs4xx_rx_i,
  input wire logic daughter_tx_data_i,
  input wire logic daughter_tx_clock_i,
  output logic rs232_tx1_o,
  output logic rs232_tx2_o,
  output logic rs4xx_tx_o,
  output logic rs4xx_de_o,
  output logic rs4xx_re_n_o,
  output logic termination_enable_o,
  output logic daughter_rx_data_o,
  output logic daughter_rx_clock_o,
  output logic [4:0] link_tx_frame_o,
  output logic link_tx_strobe_o,
  input wire logic [4:0] link_rx_frame_i,
  input wire logic link_rx_strobe_i,
  input wire logic deser_lock_i,
  input wire logic deser_err_i,
  input wire logic deser_sync_i,
  input wire logic optical_sd_i,
  output logic local_link_good_o,
  output logic remote_link_sync_o,
  output logic optical_present_o,
  output logic tx_activity_ch1_o,
  output logic tx_activity_ch2_o,
  output logic tx_activity_ch3_o,
  output logic rx_activity_ch1_o,
  output logic rx_activity_ch2_o,
  output logic rx_activity_ch3_o
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  localparam int PIN_N = 9;
  localparam int P_RX1 = 0;
  localparam int P_RX2 = 1;
  localparam int P_RX3 = 2;
  localparam int P_DDATA = 3;
  localparam int P_DCLK = 4;
  localparam int P_LOCK = 5;
  localparam int P_ERR = 6;
  localparam int P_SYNC = 7;
  localparam int P_SD = 8;

  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] meta_reg;
  logic [PIN_N-1:0] pin_reg;

  assign pin_raw = {optical_sd_i, deser_sync_i, deser_err_i, deser_lock_i,
                    daughter_tx_clock_i, daughter_tx_data_i, rs4xx_rx_i,
                    rs232_rx2_i, rs232_rx1_i};

  genvar g;
  generate
    for (g = 0; g < PIN_N; g++) begin : g_sync
      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          meta_reg[g] <= 1'b0;
          pin_reg[g] <= 1'b0;
        end else begin
          meta_reg[g] <= pin_raw[g];
          pin_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Configuration register

  localparam int IRQ_MASK_W = sct_pkg::IRQ_W;
  logic [31:0] ctrl_reg;
  logic [IRQ_MASK_W-1:0] irq_mask_reg;
  logic [sct_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [sct_pkg::IRQ_W-1:0] irq_set;
  logic mode_422;
  logic autobaud;
  logic [2:0] rate_raw;
  logic [2:0] rate_sel;
  logic [15:0] sel_bit;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= sct_pkg::CTRL_RESET;
    end else if (reg_wr_i && reg_addr_i == sct_pkg::REG_CTRL) begin
      ctrl_reg <= reg_wdata_i & 32'h0000_007F;
    end
  end

  // both selects must be set for RS-422
  assign mode_422 = ctrl_reg[sct_pkg::CTRL_SEL_A]
                    && ctrl_reg[sct_pkg::CTRL_SEL_B];
  assign autobaud = ctrl_reg[sct_pkg::CTRL_AUTOBAUD];
  assign rate_raw = ctrl_reg[sct_pkg::CTRL_RATE_LSB +: 3];
  assign rate_sel = (rate_raw > 3'h5) ? 3'h5 : rate_raw;

  always_comb begin
    unique case (rate_sel)
      3'h0: sel_bit = 16'(sct_pkg::CLK_HZ / sct_pkg::BAUD_9K6);
      3'h1: sel_bit = 16'(sct_pkg::CLK_HZ / sct_pkg::BAUD_19K2);
      3'h2: sel_bit = 16'(sct_pkg::CLK_HZ / sct_pkg::BAUD_38K4);
      3'h3: sel_bit = 16'(sct_pkg::CLK_HZ / sct_pkg::BAUD_57K6);
      3'h4: sel_bit = 16'(sct_pkg::CLK_HZ / sct_pkg::BAUD_115K2);
      default: sel_bit = 16'(sct_pkg::CLK_HZ / sct_pkg::BAUD_230K4);
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      termination_enable_o <= 1'b0;
    end else begin
      termination_enable_o <= ctrl_reg[sct_pkg::CTRL_TERM];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sub units

  sct_ch_if ch ();

  sct_turnaround u_turn (
    .sys_clk_i (sys_clk_i),
    .rst_n_i (rst_n_i),
    .ch (ch.ta_mp)
  );

  sct_activity #(
    .HOLD_CYC (ACT_HOLD_CYC)
  ) u_act (
    .sys_clk_i (sys_clk_i),
    .rst_n_i (rst_n_i),
    .ch (ch.act_mp)
  );

  ////////////////////////////////////////////////////////////////////////
  // Link status

  logic local_good;
  logic err_prev_reg;

  assign local_good = pin_reg[P_LOCK] && !pin_reg[P_ERR];

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      local_link_good_o <= 1'b0;
      remote_link_sync_o <= 1'b0;
      optical_present_o <= 1'b0;
      err_prev_reg <= 1'b0;
    end else begin
      local_link_good_o <= local_good;
      remote_link_sync_o <= local_good && pin_reg[P_SYNC];
      optical_present_o <= pin_reg[P_SD];
      err_prev_reg <= pin_reg[P_ERR];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outgoing frame

  logic [3:0] div_reg;
  logic tick;
  logic ch3_local;

  assign tick = (div_reg == sct_pkg::SAMPLE_LAST);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      div_reg <= 4'h0;
    end else if (tick) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  assign ch3_local = (mode_422 || !ch.drive_en) ? pin_reg[P_RX3] : 1'b1;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      link_tx_frame_o <= 5'h1F;
      link_tx_strobe_o <= 1'b0;
    end else begin
      link_tx_strobe_o <= tick;
      if (tick) begin
        link_tx_frame_o[sct_pkg::FR_CH1] <= pin_reg[P_RX1];
        link_tx_frame_o[sct_pkg::FR_CH2] <= pin_reg[P_RX2];
        link_tx_frame_o[sct_pkg::FR_CH3] <= ch3_local;
        link_tx_frame_o[sct_pkg::FR_DDATA] <= pin_reg[P_DDATA];
        link_tx_frame_o[sct_pkg::FR_DCLK] <= pin_reg[P_DCLK];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Incoming frame

  logic [4:0] rx_frame_reg;

  // unpack only from a good link
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rx_frame_reg <= 5'h07;
    end else if (!local_good) begin
      rx_frame_reg <= 5'h07;
    end else if (link_rx_strobe_i) begin
      rx_frame_reg <= link_rx_frame_i;
    end
  end

  assign ch.link_ch3 = rx_frame_reg[sct_pkg::FR_CH3];
  assign ch.mode_422 = mode_422;
  assign ch.autobaud = autobaud;
  assign ch.sel_bit = sel_bit;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rs232_tx1_o <= 1'b1;
      rs232_tx2_o <= 1'b1;
      rs4xx_tx_o <= 1'b1;
      rs4xx_de_o <= 1'b0;
      rs4xx_re_n_o <= 1'b0;
      daughter_rx_data_o <= 1'b0;
      daughter_rx_clock_o <= 1'b0;
    end else begin
      rs232_tx1_o <= rx_frame_reg[sct_pkg::FR_CH1];
      rs232_tx2_o <= rx_frame_reg[sct_pkg::FR_CH2];
      rs4xx_tx_o <= rx_frame_reg[sct_pkg::FR_CH3];
      rs4xx_de_o <= ch.drive_en;
      rs4xx_re_n_o <= ch.drive_en && !mode_422;
      daughter_rx_data_o <= rx_frame_reg[sct_pkg::FR_DDATA];
      daughter_rx_clock_o <= rx_frame_reg[sct_pkg::FR_DCLK];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Activity lamps

  logic [2:0] rx_prev_reg;
  logic [2:0] tx_prev_reg;
  logic [2:0] rx_now;
  logic [2:0] tx_now;

  assign rx_now = {ch3_local, pin_reg[P_RX2], pin_reg[P_RX1]};
  assign tx_now = {rx_frame_reg[sct_pkg::FR_CH3],
                   rx_frame_reg[sct_pkg::FR_CH2],
                   rx_frame_reg[sct_pkg::FR_CH1]};

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rx_prev_reg <= 3'h7;
      tx_prev_reg <= 3'h7;
    end else begin
      rx_prev_reg <= rx_now;
      tx_prev_reg <= tx_now;
    end
  end

  assign ch.act_edge = {rx_now ^ rx_prev_reg, tx_now ^ tx_prev_reg};

  assign tx_activity_ch1_o = ch.act_lamp[0];
  assign tx_activity_ch2_o = ch.act_lamp[1];
  assign tx_activity_ch3_o = ch.act_lamp[2];
  assign rx_activity_ch1_o = ch.act_lamp[3];
  assign rx_activity_ch2_o = ch.act_lamp[4];
  assign rx_activity_ch3_o = ch.act_lamp[5];

  ////////////////////////////////////////////////////////////////////////
  // Interrupts

  logic [sct_pkg::IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set = '0;
    irq_set[sct_pkg::IRQ_LOCAL_LOST] = local_link_good_o && !local_good;
    irq_set[sct_pkg::IRQ_REMOTE_LOST] = remote_link_sync_o
                                        && !(local_good && pin_reg[P_SYNC]);
    irq_set[sct_pkg::IRQ_OPTICAL_LOST] = optical_present_o && !pin_reg[P_SD];
    irq_set[sct_pkg::IRQ_FRAME_ERR] = pin_reg[P_ERR] && !err_prev_reg;
  end

  assign irq_clr = (reg_wr_i && reg_addr_i == sct_pkg::REG_IRQ_STAT)
                   ? reg_wdata_i[sct_pkg::IRQ_W-1:0] : '0;

  // New events win over a clear
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_mask_reg <= '0;
    end else if (reg_wr_i && reg_addr_i == sct_pkg::REG_IRQ_MASK) begin
      irq_mask_reg <= reg_wdata_i[sct_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read

  logic [31:0] status_word;

  assign status_word = {27'h000_0000, mode_422, ch.drive_en,
                        optical_present_o, remote_link_sync_o,
                        local_link_good_o};

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        sct_pkg::REG_CTRL: reg_rdata_o <= ctrl_reg;
        sct_pkg::REG_STATUS: reg_rdata_o <= status_word;
        sct_pkg::REG_IRQ_STAT: reg_rdata_o <= 32'(irq_stat_reg);
        sct_pkg::REG_IRQ_MASK: reg_rdata_o <= 32'(irq_mask_reg);
        sct_pkg::REG_BIT_TIME: reg_rdata_o <= 32'(ch.eff_bit);
        default: reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// ===== dv/sct_checker.sv
// Port checker for the serial channel transport top.
// Assumes it is bound into sct_top and shares its clock.
`timescale 1ns/10ps
`default_nettype none
module sct_checker #(
  parameter int ACT_HOLD_CYC = 8
) (
  input wire logic sys_clk_i, rst_n_i, rs232_rx1_i, deser_lock_i,
  input wire logic deser_err_i, deser_sync_i, optical_sd_i, irq_o,
  input wire logic local_link_good_o, remote_link_sync_o, optical_present_o,
  input wire logic link_tx_strobe_o, rs4xx_de_o, rs4xx_re_n_o, rs4xx_tx_o,
  input wire logic rs232_tx1_o, tx_activity_ch1_o, rx_activity_ch1_o,
  input wire logic termination_enable_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic prev_reg;
  int idle_reg;
  // Cycles since the last receive line change
  always_ff @(posedge sys_clk_i) begin
    prev_reg <= rs232_rx1_i;
    if (!rst_n_i || prev_reg != rs232_rx1_i) begin
      idle_reg <= 0;
    end else if (idle_reg < ACT_HOLD_CYC + 16) begin
      idle_reg <= idle_reg + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_local_good;
    (deser_lock_i && !deser_err_i)[*5] |-> ##[0:3] local_link_good_o;
  endproperty
  a_local_good: assert property (p_local_good)
    else $error("local link good missing");
  property p_local_bad;
    deser_err_i[*5] |-> !local_link_good_o;
  endproperty
  a_local_bad: assert property (p_local_bad)
    else $error("local link good during errors");
  property p_remote;
    (!deser_sync_i)[*5] |-> !remote_link_sync_o;
  endproperty
  a_remote: assert property (p_remote)
    else $error("remote sync without stream sync");
  property p_opt_on;
    optical_sd_i[*5] |-> optical_present_o;
  endproperty
  a_opt_on: assert property (p_opt_on)
    else $error("optical present missing");
  property p_opt_off;
    (!optical_sd_i)[*5] |-> !optical_present_o;
  endproperty
  a_opt_off: assert property (p_opt_off)
    else $error("optical present without signal");
  property p_strobe;
    link_tx_strobe_o |=> (!link_tx_strobe_o)[*7] ##1
      (!link_tx_strobe_o)[*7] ##1 link_tx_strobe_o;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("frame strobe period wrong");
  property p_reset_dflt;
    $rose(rst_n_i) |-> !rs4xx_de_o && rs4xx_tx_o && !irq_o
      ##1 termination_enable_o;
  endproperty
  a_reset_dflt: assert property (p_reset_dflt)
    else $error("reset defaults wrong");
  property p_de_start;
    $rose(rs4xx_de_o) && rs4xx_re_n_o |-> ##[0:2] !rs4xx_tx_o;
  endproperty
  a_de_start: assert property (p_de_start)
    else $error("driver on without link data");
  property p_tx_lamp;
    $changed(rs232_tx1_o) |-> ##[0:3] tx_activity_ch1_o;
  endproperty
  a_tx_lamp: assert property (p_tx_lamp)
    else $error("transmit lamp missing");
  property p_rx_lamp;
    $changed(rs232_rx1_i) |-> ##[1:6] rx_activity_ch1_o;
  endproperty
  a_rx_lamp: assert property (p_rx_lamp)
    else $error("receive lamp missing");
  property p_rx_idle;
    idle_reg > ACT_HOLD_CYC + 10 |-> !rx_activity_ch1_o;
  endproperty
  a_rx_idle: assert property (p_rx_idle)
    else $error("receive lamp stuck on");
  c_drive: cover property ($rose(rs4xx_de_o));
  c_irq: cover property ($rose(irq_o));
  c_lost: cover property ($fell(local_link_good_o));
endmodule
bind sct_top sct_checker #(.ACT_HOLD_CYC(ACT_HOLD_CYC)) i_sct_checker (.*);
`default_nettype wire

// ===== dv/sct_remote_model.sv
// Far board model: frames toward the block and deserializer status.
// Assumes the link frames share the system clock.
`timescale 1ns/10ps
`default_nettype none
module sct_remote_model #(
  parameter int PERIOD = 15
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic fiber_ok_i,
  input wire logic err_i,
  input wire logic [4:0] far_lines_i,
  input wire logic [4:0] near_frame_i,
  input wire logic near_strobe_i,
  output logic [4:0] rx_frame_o,
  output logic rx_strobe_o,
  output logic lock_o,
  output logic err_o,
  output logic sync_o,
  output logic sd_o,
  output logic [4:0] heard_frame_o
);
  logic [3:0] cnt_reg;
  logic heard_reg;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 4'h0;
      rx_strobe_o <= 1'b0;
      rx_frame_o <= 5'h1F;
    end else begin
      cnt_reg <= (cnt_reg == 4'(PERIOD - 1)) ? 4'h0 : cnt_reg + 4'h1;
      rx_strobe_o <= fiber_ok_i && cnt_reg == 4'h0;
      rx_frame_o <= (fiber_ok_i && cnt_reg == 4'h0) ? far_lines_i
                                                    : ~rx_frame_o;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    lock_o <= fiber_ok_i;
    sd_o <= fiber_ok_i;
    err_o <= err_i;
    sync_o <= fiber_ok_i && heard_reg;
    if (!rst_n_i || !fiber_ok_i) begin
      heard_reg <= 1'b0;
    end else if (near_strobe_i) begin
      heard_reg <= 1'b1;
      heard_frame_o <= near_frame_i;
    end
  end
endmodule
`default_nettype wire

// ===== dv/sct_top_tb_top.sv
// Testbench for the serial channel transport top.
// Assumes the far board model and the bound port checker.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %0h got %0h", n, e, a); end end
module sct_top_tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic rs232_rx1_i = 1'b1;
  logic rs232_rx2_i = 1'b1;
  logic rs4xx_rx_i = 1'b1;
  logic daughter_tx_data_i = 1'b1;
  logic daughter_tx_clock_i = 1'b1;
  logic fiber_ok = 1'b0;
  logic err_in = 1'b0;
  logic [4:0] far_lines = 5'h1F;
  logic [31:0] reg_rdata_o, rd_val;
  logic [4:0] link_tx_frame_o, link_rx_frame_i, heard;
  logic irq_o, rs232_tx1_o, rs232_tx2_o, rs4xx_tx_o, rs4xx_de_o;
  logic rs4xx_re_n_o, termination_enable_o, daughter_rx_data_o;
  logic daughter_rx_clock_o, link_tx_strobe_o, link_rx_strobe_i;
  logic deser_lock_i, deser_err_i, deser_sync_i, optical_sd_i;
  logic local_link_good_o, remote_link_sync_o, optical_present_o;
  logic tx_activity_ch1_o, tx_activity_ch2_o, tx_activity_ch3_o;
  logic rx_activity_ch1_o, rx_activity_ch2_o, rx_activity_ch3_o;
  int n_errors = 0;
  int checks = 0;
  int i;
  always #2 sys_clk_i = ~sys_clk_i;
  sct_top #(.ACT_HOLD_CYC(8)) i_sct_top (.*);
  sct_remote_model i_sct_remote_model (
    .sys_clk_i, .rst_n_i, .fiber_ok_i(fiber_ok), .err_i(err_in),
    .far_lines_i(far_lines), .near_frame_i(link_tx_frame_o),
    .near_strobe_i(link_tx_strobe_o), .rx_frame_o(link_rx_frame_i),
    .rx_strobe_o(link_rx_strobe_i), .lock_o(deser_lock_i),
    .err_o(deser_err_i), .sync_o(deser_sync_i), .sd_o(optical_sd_i),
    .heard_frame_o(heard));
  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic chk_reg(input string n, input logic [7:0] a,
                         input logic [31:0] e);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge sys_clk_i);
    rd_val = reg_rdata_o;
    `CHK(n, e, rd_val)
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    n_errors++;
    $display("mismatch watchdog exp done got timeout");
    finish_test();
  end
  initial begin
    cyc(3);
    rst_n_i <= 1'b1;
    chk_reg("ctrl", sct_pkg::REG_CTRL, sct_pkg::CTRL_RESET);
    `CHK("term", 1'b1, termination_enable_o)
    `CHK("local", 1'b0, local_link_good_o)
    $display("test reset done");
    fiber_ok <= 1'b1;
    cyc(80);
    chk_reg("status", sct_pkg::REG_STATUS, 32'h0000_0007);
    `CHK("local", 1'b1, local_link_good_o)
    `CHK("optical", 1'b1, optical_present_o)
    err_in <= 1'b1;
    cyc(10);
    `CHK("local err", 1'b0, local_link_good_o)
    `CHK("remote err", 1'b0, remote_link_sync_o)
    `CHK("optical err", 1'b1, optical_present_o)
    err_in <= 1'b0;
    cyc(20);
    $display("test link done");
    `CHK("de idle", 1'b0, rs4xx_de_o)
    rs232_rx1_i <= 1'b0;
    rs4xx_rx_i <= 1'b0;
    daughter_tx_clock_i <= 1'b0;
    cyc(40);
    `CHK("near frame", 5'h0A, heard)
    rs232_rx1_i <= 1'b1;
    rs4xx_rx_i <= 1'b1;
    daughter_tx_clock_i <= 1'b1;
    far_lines <= 5'h12;
    cyc(40);
    `CHK("far outs", 5'h12, {daughter_rx_clock_o, daughter_rx_data_o,
         rs4xx_tx_o, rs232_tx2_o, rs232_tx1_o})
    `CHK("de drive", 2'b11, {rs4xx_de_o, rs4xx_re_n_o})
    far_lines <= 5'h1F;
    cyc(40000);
    `CHK("de hold", 1'b1, rs4xx_de_o)
    chk_reg("bit max", sct_pkg::REG_BIT_TIME,
            32'(sct_pkg::CLK_HZ / sct_pkg::BAUD_57K6));
    cyc(5000);
    `CHK("de release", 2'b00, {rs4xx_de_o, rs4xx_re_n_o})
    chk_reg("bit idle", sct_pkg::REG_BIT_TIME,
            32'(sct_pkg::CLK_HZ / sct_pkg::BAUD_9K6));
    $display("test data done");
    rs232_rx2_i <= 1'b0;
    rs4xx_rx_i <= 1'b0;
    for (i = 0; i < 10 && {rx_activity_ch2_o, rx_activity_ch3_o} !== 2'b11;
         i++) cyc(1);
    `CHK("rx lamps", 2'b11, {rx_activity_ch2_o, rx_activity_ch3_o})
    cyc(30);
    `CHK("rx lamps off", 2'b00, {rx_activity_ch2_o, rx_activity_ch3_o})
    far_lines <= 5'h1D;
    for (i = 0; i < 40 && tx_activity_ch2_o !== 1'b1; i++) cyc(1);
    `CHK("tx lamp", 1'b1, tx_activity_ch2_o)
    cyc(40);
    `CHK("tx lamp off", 1'b0, tx_activity_ch2_o)
    rs232_rx2_i <= 1'b1;
    rs4xx_rx_i <= 1'b1;
    far_lines <= 5'h1F;
    cyc(40);
    $display("test lamps done");
    wr_reg(sct_pkg::REG_IRQ_STAT, 32'h0000_000F);
    wr_reg(sct_pkg::REG_IRQ_MASK, 32'h0000_0001);
    fiber_ok <= 1'b0;
    cyc(20);
    chk_reg("irq stat", sct_pkg::REG_IRQ_STAT, 32'h0000_0007);
    `CHK("irq on", 1'b1, irq_o)
    wr_reg(sct_pkg::REG_IRQ_STAT, 32'h0000_0001);
    chk_reg("irq w1c", sct_pkg::REG_IRQ_STAT, 32'h0000_0006);
    `CHK("irq masked", 1'b0, irq_o)
    wr_reg(sct_pkg::REG_IRQ_MASK, 32'h0000_0004);
    cyc(2);
    `CHK("irq unmasked", 1'b1, irq_o)
    wr_reg(sct_pkg::REG_IRQ_STAT, 32'h0000_0006);
    cyc(2);
    `CHK("irq clear", 1'b0, irq_o)
    fiber_ok <= 1'b1;
    cyc(80);
    $display("test irq done");
    wr_reg(sct_pkg::REG_CTRL, 32'hFFFF_FF83);
    chk_reg("ctrl mask", sct_pkg::REG_CTRL, 32'h0000_0003);
    cyc(4);
    `CHK("422 pins", 3'b100, {rs4xx_de_o, rs4xx_re_n_o,
         termination_enable_o})
    chk_reg("status 422", sct_pkg::REG_STATUS, 32'h0000_001F);
    for (i = 0; i < 6; i++) begin
      wr_reg(sct_pkg::REG_CTRL, 32'(i << 2) | 32'h0000_0040);
      chk_reg("rate", sct_pkg::REG_CTRL, 32'(i << 2) | 32'h0000_0040);
    end
    wr_reg(8'h20, 32'hFFFF_FFFF);
    chk_reg("unmapped", 8'h20, 32'h0000_0000);
    chk_reg("ctrl kept", sct_pkg::REG_CTRL, 32'h0000_0054);
    chk_reg("bit fixed", sct_pkg::REG_BIT_TIME,
            32'(sct_pkg::CLK_HZ / sct_pkg::BAUD_230K4));
    $display("test config done");
    finish_test();
  end
endmodule
`default_nettype wire
